// ==== inc/standby_params.svh ====
// standby_params.svh: register address, field positions, reset values and warm-up counts
// assumes: included by bare name from the standby block and its package users
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH

`define WHC_ADDR          16'hffd2
`define WHC_RETAIN_BIT    0
`define WHC_MODE_LO       2
`define WHC_MODE_HI       3
`define WHC_WARM_BIT      4
`define WHC_RETAIN_RST    1'b0
`define WHC_MODE_RST      2'h0
`define WHC_WARM_RST      1'b0
`define WARM_SHORT_CYC    16384
`define WARM_LONG_CYC     65536
`define WARM_CNT_W        17

`endif

// ==== inc/standby_pkg.sv ====
// standby_pkg: types shared by the standby sequencer
// assumes: compiled before any design file
package standby_pkg;

  typedef enum logic [1:0] {
    HM_RUN  = 2'h0,
    HM_STOP = 2'h1,
    HM_IDLE = 2'h2,
    HM_RSVD = 2'h3
  } halt_mode_t;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_HALT_RUN,
    ST_IDLE,
    ST_STOP,
    ST_WARMUP
  } standby_state_t;

endpackage

// ==== hdl/warmup_counter.sv ====
// warmup_counter: counts the oscillator warm-up after a stop-mode wake
// assumes: start_i is a one-cycle pulse from the sequencer on core_clk_i
`timescale 1ns/10ps
`default_nettype none
`include "standby_params.svh"

module warmup_counter #(
  parameter int unsigned SHORT_CYC = `WARM_SHORT_CYC,
  parameter int unsigned LONG_CYC  = `WARM_LONG_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  input  wire logic long_i,
  output logic      done_o
);

  logic [`WARM_CNT_W-1:0] cnt_q;
  logic                   busy_q;

  // length chosen at start so a later change of the select cannot stretch a run
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= long_i ? `WARM_CNT_W'(LONG_CYC - 1) : `WARM_CNT_W'(SHORT_CYC - 1);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - `WARM_CNT_W'(1);
      end
    end
  end

  assign done_o = busy_q && (cnt_q == '0);

endmodule
`default_nettype wire

// ==== hdl/standby_idle_stop_control.sv ====
// standby_idle_stop_control: halt-mode sequencer for run, oscillator-only idle and stop
// assumes: cpu strobes and register port on core_clk_i; interrupt request and pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "standby_params.svh"

// Function
// - idle keeps oscillator only, stops system clock, holds clock pin at one.
// - idle samples interrupts without system clock; release happens on the clock.
// - stop halts everything including the oscillator.
// - stop with retain bit clear floats pins and isolates all but the interrupt pin.
// - retain bit at bit 0 set keeps the port pins in their pre-halt state; ale still goes low and the oscillator pin high.
// - reset clears the retain bit.
// - stop wake by interrupt restarts oscillator, clock only after warm-up.
// - warm-up select bit 4 gives 2^14 periods when 0, 2^16 when 1.
// - reset clears the warm-up select bit.
// - reset low also restarts the oscillator out of stop.
// - leaving stop by reset skips warm-up and resumes at once.
// - pins unusable in stop get input disabled and outputs floated.
// - halt mode bits 3:2 pick run, stop or idle; reset selects run.
// - standby permit low turns halt into run mode, watchdog keeps counting.
module standby_idle_stop_control #(
  parameter int unsigned NUM_PINS      = 8,
  parameter int unsigned EXT_IRQ_A_IDX = 0,
  parameter int unsigned SHORT_CYC     = `WARM_SHORT_CYC,
  parameter int unsigned LONG_CYC      = `WARM_LONG_CYC
) (
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic [15:0]         addr_i,
  input  wire logic                wr_en_i,
  input  wire logic                rd_en_i,
  input  wire logic [7:0]          wdata_i,
  output logic      [7:0]          rdata_o,
  input  wire logic                halt_exec_i,
  input  wire logic                irq_req_i,
  input  wire logic                standby_permit_i,
  input  wire logic                ale_core_i,
  input  wire logic [NUM_PINS-1:0] pin_out_core_i,
  input  wire logic [NUM_PINS-1:0] pin_oe_n_core_i,
  output logic      [NUM_PINS-1:0] pin_out_o,
  output logic      [NUM_PINS-1:0] pin_oe_n_o,
  output logic      [NUM_PINS-1:0] pin_in_en_o,
  output logic                     ale_o,
  output logic                     osc_out_high_o,
  output logic                     osc_run_o,
  output logic                     sys_clk_en_o,
  output logic                     clk_pin_high_o,
  output logic                     cpu_halted_o,
  output logic                     halt_release_o,
  output logic                     watchdog_run_o
);

  ////////////////////////////////////////////////////////////////////////////
  // control register
  logic                   retain_q;
  logic                   warm_q;
  standby_pkg::halt_mode_t mode_q;
  standby_pkg::standby_state_t state_q;
  logic                   irq_meta_q;
  logic                   irq_sync_q;
  logic                   warm_start;
  logic                   warm_done;
  logic                   in_stop;

  function automatic logic hits(input logic [15:0] a);
    hits = (a == `WHC_ADDR);
  endfunction

  // writes only land while the cpu runs; a halted cpu cannot issue them anyway
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      retain_q <= `WHC_RETAIN_RST;
      warm_q   <= `WHC_WARM_RST;
      mode_q   <= standby_pkg::halt_mode_t'(`WHC_MODE_RST);
    end else if (wr_en_i && hits(addr_i) && state_q == standby_pkg::ST_ACTIVE) begin
      retain_q <= wdata_i[`WHC_RETAIN_BIT];
      warm_q   <= wdata_i[`WHC_WARM_BIT];
      mode_q   <= standby_pkg::halt_mode_t'(wdata_i[`WHC_MODE_HI:`WHC_MODE_LO]);
    end
  end

  // bits owned by other blocks read as zero here
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      rdata_o <= 8'h00;
      if (hits(addr_i)) begin
        rdata_o[`WHC_RETAIN_BIT]            <= retain_q;
        rdata_o[`WHC_WARM_BIT]              <= warm_q;
        rdata_o[`WHC_MODE_HI:`WHC_MODE_LO]  <= mode_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request synchroniser: request is asynchronous to the system clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_req_i;
      irq_sync_q <= irq_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt sequencer; async reset lands in active with no warm-up at all
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= standby_pkg::ST_ACTIVE;
    end else begin
      unique case (state_q)
        standby_pkg::ST_ACTIVE: begin
          if (halt_exec_i) begin
            if (!standby_permit_i) begin
              state_q <= standby_pkg::ST_HALT_RUN;
            end else if (mode_q == standby_pkg::HM_STOP) begin
              state_q <= standby_pkg::ST_STOP;
            end else if (mode_q == standby_pkg::HM_IDLE) begin
              state_q <= standby_pkg::ST_IDLE;
            end else begin
              state_q <= standby_pkg::ST_HALT_RUN;
            end
          end
        end
        standby_pkg::ST_HALT_RUN,
        standby_pkg::ST_IDLE: begin
          if (irq_sync_q) begin
            state_q <= standby_pkg::ST_ACTIVE;
          end
        end
        standby_pkg::ST_STOP: begin
          if (irq_sync_q) begin
            state_q <= standby_pkg::ST_WARMUP;
          end
        end
        standby_pkg::ST_WARMUP: begin
          if (warm_done) begin
            state_q <= standby_pkg::ST_ACTIVE;
          end
        end
      endcase
    end
  end

  assign warm_start = (state_q == standby_pkg::ST_STOP) && irq_sync_q;

  warmup_counter #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_warm (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .start_i    (warm_start),
    .long_i     (warm_q),
    .done_o     (warm_done)
  );

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_release_o <= 1'b0;
    end else begin
      halt_release_o <= irq_sync_q && (state_q == standby_pkg::ST_HALT_RUN || state_q == standby_pkg::ST_IDLE);
    end
  end

  assign sys_clk_en_o   = (state_q == standby_pkg::ST_ACTIVE) || (state_q == standby_pkg::ST_HALT_RUN);
  assign osc_run_o      = (state_q != standby_pkg::ST_STOP);
  assign clk_pin_high_o = !sys_clk_en_o;
  assign cpu_halted_o   = (state_q != standby_pkg::ST_ACTIVE);
  assign watchdog_run_o = sys_clk_en_o;
  // pins stay parked through warm-up since the cpu has not resumed yet
  assign in_stop        = (state_q == standby_pkg::ST_STOP) || (state_q == standby_pkg::ST_WARMUP);

  ////////////////////////////////////////////////////////////////////////////
  // pin control; one cycle of lag, so the last pre-halt value is what gets held
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_out_o[i]   <= 1'b0;
          pin_oe_n_o[i]  <= 1'b1;
          pin_in_en_o[i] <= 1'b1;
        end else if (!in_stop) begin
          pin_out_o[i]   <= pin_out_core_i[i];
          pin_oe_n_o[i]  <= pin_oe_n_core_i[i];
          pin_in_en_o[i] <= 1'b1;
        end else if (!retain_q) begin
          pin_out_o[i]   <= 1'b0;
          pin_oe_n_o[i]  <= 1'b1;
          pin_in_en_o[i] <= (i == EXT_IRQ_A_IDX);
        end else begin
          pin_in_en_o[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ale_o          <= 1'b0;
      osc_out_high_o <= 1'b0;
    end else begin
      ale_o          <= in_stop ? 1'b0 : ale_core_i;
      osc_out_high_o <= in_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [`WARM_CNT_W-1:0] warm_seen_q;
  logic                   warmup_st;
  assign warmup_st = (state_q == standby_pkg::ST_WARMUP);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_seen_q <= '0;
    end else begin
      warm_seen_q <= warmup_st ? warm_seen_q + `WARM_CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  idle_clock_stop_a: assert property (
    state_q == standby_pkg::ST_IDLE |-> !sys_clk_en_o && osc_run_o && clk_pin_high_o)
    else $error("idle mode clock outputs wrong");
  idle_wake_a: assert property (
    state_q == standby_pkg::ST_IDLE && irq_sync_q |=> state_q == standby_pkg::ST_ACTIVE && halt_release_o)
    else $error("idle wake not taken on the next clock");
  stop_osc_off_a: assert property (
    state_q == standby_pkg::ST_STOP |-> !osc_run_o && !sys_clk_en_o && !watchdog_run_o)
    else $error("oscillator running in stop");
  stop_float_a: assert property (
    in_stop && $past(in_stop) && !retain_q |-> (&pin_oe_n_o) && pin_in_en_o == (NUM_PINS'(1) << EXT_IRQ_A_IDX))
    else $error("pins not floated in stop");
  stop_retain_a: assert property (
    in_stop && $past(in_stop) && retain_q |-> $stable(pin_out_o) && $stable(pin_oe_n_o) && (&pin_in_en_o))
    else $error("pins not held in stop");
  reset_fields_a: assert property (
    $rose(resetn_i) |-> !retain_q && !warm_q && mode_q == standby_pkg::HM_RUN)
    else $error("control fields not cleared by reset");
  reset_resume_a: assert property (
    $rose(resetn_i) |-> state_q == standby_pkg::ST_ACTIVE && osc_run_o && sys_clk_en_o)
    else $error("reset did not resume at once");
  warm_gate_a: assert property (
    warmup_st |-> osc_run_o && !sys_clk_en_o)
    else $error("system clock before warm-up end");
  warm_length_a: assert property (
    $fell(warmup_st) |-> warm_seen_q == (warm_q ? `WARM_CNT_W'(LONG_CYC) : `WARM_CNT_W'(SHORT_CYC)))
    else $error("warm-up length wrong");
  permit_off_a: assert property (
    state_q == standby_pkg::ST_ACTIVE && halt_exec_i && !standby_permit_i
      |=> state_q == standby_pkg::ST_HALT_RUN && watchdog_run_o)
    else $error("halt entered standby without permit");
  mode_select_a: assert property (
    state_q == standby_pkg::ST_ACTIVE && halt_exec_i && standby_permit_i && mode_q == standby_pkg::HM_STOP
      |=> state_q == standby_pkg::ST_STOP)
    else $error("stop mode not entered");
  stop_pins_a: assert property (
    in_stop && $past(in_stop) |-> !ale_o && osc_out_high_o)
    else $error("strobe or oscillator pin wrong in stop");

  idle_wake_c: cover property (state_q == standby_pkg::ST_IDLE ##1 state_q == standby_pkg::ST_ACTIVE);
  stop_wake_c: cover property ($fell(warmup_st));
  halt_run_c:  cover property (state_q == standby_pkg::ST_HALT_RUN ##1 state_q == standby_pkg::ST_ACTIVE);

endmodule
`default_nettype wire

// ==== verification/cpu_pin_model.sv ====
// cpu_pin_model: core, interrupt source and pin drivers facing the sequencer
// assumes: one clock, wake_i is a one-cycle command from the bench
`timescale 1ns/10ps
`default_nettype none
module cpu_pin_model (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wake_i,
  input  wire logic [7:0] pat_i,
  output logic            irq_req_o,
  output logic            ale_o,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_n_o
);
  logic [2:0] hold_q;
  // request held four cycles: the sequencer syncs it through two flops
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) hold_q <= 3'h0;
    else if (wake_i) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  assign irq_req_o = (hold_q != 3'h0);
  // strobe toggles every cycle so a stale copy during stop shows up
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) ale_o <= 1'b0;
    else ale_o <= ~ale_o;
  end
  assign pin_out_o  = pat_i;
  assign pin_oe_n_o = ~pat_i;
endmodule
`default_nettype wire

// ==== verification/standby_idle_stop_control_test.sv ====
// standby_idle_stop_control_test: self-checking bench for the halt-mode sequencer
// assumes: cpu_pin_model drives core strobes, pins and the interrupt request
`timescale 1ns/10ps
`default_nettype none
module standby_idle_stop_control_test;
  localparam int SH = 16;
  localparam int LG = 64;
  logic        clk, rstn, wr, rd, halt, permit, wake, irq, ale_core, ale, osc_hi;
  logic        osc_run, sclk, clk_hi, halted, rel, wdog;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, pat, pin_out, pin_oe_n, pin_in_en, core_out, core_oe_n, got;
  int          n_mismatch, compares, n, i;
  // address, write data, expected read back; unused bits read zero
  logic [31:0] rows [4] = '{32'hffd2_05_05, 32'hffd2_ff_1d, 32'hffd2_10_10, 32'hffd0_aa_00};

  cpu_pin_model cpu (.core_clk_i(clk), .resetn_i(rstn), .wake_i(wake), .pat_i(pat), .irq_req_o(irq),
    .ale_o(ale_core), .pin_out_o(core_out), .pin_oe_n_o(core_oe_n));
  standby_idle_stop_control #(.SHORT_CYC(SH), .LONG_CYC(LG)) DUT (.core_clk_i(clk), .resetn_i(rstn),
    .addr_i(addr), .wr_en_i(wr), .rd_en_i(rd), .wdata_i(wdata), .rdata_o(rdata), .halt_exec_i(halt),
    .irq_req_i(irq), .standby_permit_i(permit), .ale_core_i(ale_core), .pin_out_core_i(core_out),
    .pin_oe_n_core_i(core_oe_n), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pin_in_en_o(pin_in_en),
    .ale_o(ale), .osc_out_high_o(osc_hi), .osc_run_o(osc_run), .sys_clk_en_o(sclk),
    .clk_pin_high_o(clk_hi), .cpu_halted_o(halted), .halt_release_o(rel), .watchdog_run_o(wdog));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    cyc(1);
    v = rdata;
  endtask
  task automatic pulse(input bit is_wake);
    @(posedge clk);
    if (is_wake) wake <= 1'b1;
    else halt <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    halt <= 1'b0;
    #1;
  endtask
  // bounded wait on the oscillator enable (0) or the system clock enable (1)
  task automatic wait_on(input bit use_clk);
    n = 0;
    while (((use_clk ? sclk : osc_run) !== 1'b1) && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // stop entry with a given register byte, then wake and time the warm-up
  task automatic stop_run(input logic [7:0] cfg, input int warm);
    wr_reg(16'hffd2, cfg);
    pulse(1'b0);
    chk("osc_run", osc_run, 1'b0);
    chk("clk_pin", {clk_hi, wdog}, 2'b10);
    cyc(1);
    chk("ale_osc", {ale, osc_hi}, 2'b01);
    if (cfg[0]) begin
      chk("pins_held", {pin_out, pin_oe_n}, {8'h5a, 8'ha5});
      chk("in_en", pin_in_en, 8'hff);
    end else begin
      chk("pins_float", {pin_out, pin_oe_n}, {8'h00, 8'hff});
      chk("in_en", pin_in_en, 8'h01);
    end
    wr_reg(16'hffd2, 8'h00);
    pulse(1'b1);
    wait_on(1'b0);
    chk("no_clk_yet", sclk, 1'b0);
    wait_on(1'b1);
    chk("warm_len", n, warm);
    rd_reg(16'hffd2, got);
    chk("halted_write", got, cfg);
    chk("pins_back", {pin_out, pin_oe_n}, {8'h5a, 8'ha5});
    $display("test stop %h done", cfg);
  endtask

  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; halt = 1'b0; wake = 1'b0; permit = 1'b1;
    addr = 16'h0000; wdata = 8'h00; pat = 8'h5a; n_mismatch = 0; compares = 0;
    cyc(20);
    rstn <= 1'b1;
    rd_reg(16'hffd2, got);
    chk("reset_reg", got, 8'h00);
    chk("reset_out", {sclk, osc_run, clk_hi, halted}, 4'b1100);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      wr_reg(rows[i][31:16], rows[i][15:8]);
      rd_reg(rows[i][31:16], got);
      chk("reg_row", got, rows[i][7:0]);
    end
    $display("test registers done");
    wr_reg(16'hffd2, 8'h08);
    pulse(1'b0);
    chk("idle", {sclk, osc_run, clk_hi, halted, wdog}, 5'b01110);
    pulse(1'b1);
    wait_on(1'b1);
    chk("idle_rel", rel, 1'b1);
    cyc(1);
    chk("idle_rel_end", rel, 1'b0);
    $display("test idle done");
    // mode 00 and the spare code 11 both halt with the clock kept running
    for (i = 0; i < 2; i++) begin
      wr_reg(16'hffd2, i ? 8'h0c : 8'h00);
      pulse(1'b0);
      chk("run_halt", {sclk, osc_run, halted, wdog}, 4'b1111);
      pulse(1'b1);
      cyc(3);
      chk("run_rel", {rel, halted}, 2'b10);
      chk("ale_run", ale, !ale_core);
    end
    $display("test run halt done");
    stop_run(8'h04, SH);
    stop_run(8'h15, LG);
    permit <= 1'b0;
    wr_reg(16'hffd2, 8'h04);
    pulse(1'b0);
    chk("no_standby", {sclk, osc_run, halted, wdog}, 4'b1111);
    pulse(1'b1);
    cyc(6);
    chk("run_wake", halted, 1'b0);
    permit <= 1'b1;
    $display("test permit done");
    wr_reg(16'hffd2, 8'h15);
    pulse(1'b0);
    @(posedge clk);
    rstn <= 1'b0;
    // held low well beyond settling since reset skips the warm-up
    cyc(20);
    chk("osc_restart", osc_run, 1'b1);
    rstn <= 1'b1;
    cyc(1);
    chk("reset_resume", {sclk, halted}, 2'b10);
    rd_reg(16'hffd2, got);
    chk("reset_clear", got, 8'h00);
    $display("test stop reset done");
    end_of_test;
  end

  initial begin
    #(8 * 6000);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
